// ===== design/ctu_cfg.svh
// Geometry, field positions and reset values of the cache and translation unit
`ifndef CTU_CFG_SVH
`define CTU_CFG_SVH
`define CTU_IC_SETS 64
`define CTU_DC_SETS 32
`define CTU_LINE_WORDS 4
`define CTU_TLB_ENTRIES 8
`define CTU_SCR_REGS 3
`define CTU_VPN_LSB 12
`define CTU_OFS_LSB 4
`define CTU_LOW_4K 0
`define CTU_LOW_16K 2
`define CTU_LOW_512K 7
`define CTU_LOW_8M 11
`define CTU_LRU_RST 1'b0
`define CTU_IC_EXTRA 1'b0
`define CTU_DC_EXTRA 1'b1
`endif

// ===== design/ctu_pkg.sv
// Types shared by the cache and translation unit
package ctu_pkg;
    typedef enum logic [2:0] {
        CS_IDLE = 3'h0,
        CS_WBK = 3'h1,
        CS_FILL = 3'h2,
        CS_SGL = 3'h3,
        CS_LATE = 3'h4
    } ctu_cst_e;
    typedef enum logic [1:0] {LK_NONE = 2'h0, LK_SET = 2'h1, LK_CLR = 2'h2} ctu_lock_e;
    typedef enum logic [1:0] {PG_4K = 2'h0, PG_16K = 2'h1, PG_512K = 2'h2, PG_8M = 2'h3} ctu_pgsz_e;
    typedef logic [31:0] ctu_word_t;
    typedef struct packed {
        logic v;
        logic [19:0] vpn;
        logic [19:0] rpn;
        logic [3:0] asid;
        logic [3:0] grp;
        ctu_pgsz_e sz;
        logic ci;
        logic wt;
    } ctu_tlbe_s;
endpackage : ctu_pkg

// ===== design/ctu_set_cache.sv
// Two-way set-associative cache with four-word burst lines and lockable lines
`timescale 1ns/1ps
`include "ctu_cfg.svh"
module ctu_set_cache import ctu_pkg::*; #(
    parameter int SETS = `CTU_IC_SETS,
    parameter bit MISS_EXTRA = `CTU_IC_EXTRA
) (
    // Clock, reset, enable
    input logic sys_clk,
    input logic rst,
    input logic ce,
    // Translated request
    input logic req,
    input logic we,
    input ctu_word_t paddr,
    input ctu_word_t wdata,
    input logic inh,
    input logic wthru,
    input ctu_lock_e lk_op,
    output logic ready,
    output logic valid,
    output ctu_word_t rdata,
    // Memory side
    output logic m_req,
    output logic m_we,
    output logic m_burst,
    output ctu_word_t m_addr,
    output ctu_word_t m_wdata,
    input logic m_ack,
    input ctu_word_t m_rdata
);
    localparam int SB = $clog2(SETS);
    localparam int TW = 32 - SB - `CTU_OFS_LSB;
    localparam int LW = `CTU_LINE_WORDS;

    // ************************************************
    // Storage and control state
    // ************************************************
    logic [TW-1:0] tag_r [2][SETS];
    logic [TW-1:0] tag_nxt [2][SETS];
    ctu_word_t dat_r [2][SETS][LW];
    ctu_word_t dat_nxt [2][SETS][LW];
    logic [SETS-1:0] vld_r [2];
    logic [SETS-1:0] vld_nxt [2];
    logic [SETS-1:0] lck_r [2];
    logic [SETS-1:0] lck_nxt [2];
    logic [SETS-1:0] dty_r [2];
    logic [SETS-1:0] dty_nxt [2];
    logic [SETS-1:0] lru_r, lru_nxt;
    ctu_cst_e st_r, st_nxt;
    ctu_word_t a_r, a_nxt, wd_r, wd_nxt, rdata_r, rdata_nxt;
    logic we_r, we_nxt, v_r, v_nxt, valid_r, valid_nxt;
    ctu_lock_e lk_r, lk_nxt;
    logic [1:0] bt_r, bt_nxt;
    logic [SB-1:0] si, sr;
    logic [1:0] hit_w;
    logic vic, alloc_ok;

    assign si = paddr[`CTU_OFS_LSB +: SB];
    assign sr = a_r[`CTU_OFS_LSB +: SB];
    assign hit_w[0] = vld_r[0][si] && tag_r[0][si] == paddr[31 -: TW];
    assign hit_w[1] = vld_r[1][si] && tag_r[1][si] == paddr[31 -: TW];
    assign vic = lck_r[0][si] ? 1'b1 : lck_r[1][si] ? 1'b0 : !vld_r[0][si] ? 1'b0 :
                 !vld_r[1][si] ? 1'b1 : lru_r[si];
    assign alloc_ok = !(lck_r[0][si] && lck_r[1][si]);

    // ************************************************
    // Next state of lines and sequencer
    // ************************************************
    always_comb begin
        tag_nxt = tag_r;
        dat_nxt = dat_r;
        vld_nxt = vld_r;
        lck_nxt = lck_r;
        dty_nxt = dty_r;
        lru_nxt = lru_r;
        st_nxt = st_r;
        a_nxt = a_r;
        wd_nxt = wd_r;
        we_nxt = we_r;
        lk_nxt = lk_r;
        v_nxt = v_r;
        bt_nxt = bt_r;
        valid_nxt = 1'b0;
        rdata_nxt = rdata_r;
        unique case (st_r)
            CS_IDLE: if (req) begin
                a_nxt = paddr;
                wd_nxt = wdata;
                we_nxt = we;
                lk_nxt = lk_op;
                bt_nxt = 2'h0;
                if ((|hit_w) && !inh) begin
                    lru_nxt[si] = !hit_w[1];
                    if (lk_op != LK_NONE) begin
                        lck_nxt[hit_w[1]][si] = (lk_op == LK_SET);
                        valid_nxt = 1'b1;
                    end else if (we) begin
                        dat_nxt[hit_w[1]][si][paddr[3:2]] = wdata;
                        if (wthru) begin
                            st_nxt = CS_SGL;
                        end else begin
                            dty_nxt[hit_w[1]][si] = 1'b1;
                            valid_nxt = 1'b1;
                        end
                    end else begin
                        rdata_nxt = dat_r[hit_w[1]][si][paddr[3:2]];
                        valid_nxt = 1'b1;
                    end
                end else if (lk_op == LK_CLR) begin
                    valid_nxt = 1'b1;
                end else if (inh || (we && wthru) || !alloc_ok) begin
                    st_nxt = CS_SGL;
                end else begin
                    v_nxt = vic;
                    st_nxt = (vld_r[vic][si] && dty_r[vic][si]) ? CS_WBK : CS_FILL;
                end
            end
            CS_WBK: if (m_ack) begin
                bt_nxt = bt_r + 2'h1;
                if (bt_r == 2'h3) begin
                    dty_nxt[v_r][sr] = 1'b0;
                    vld_nxt[v_r][sr] = 1'b0;
                    st_nxt = CS_FILL;
                end
            end
            CS_FILL: if (m_ack) begin
                dat_nxt[v_r][sr][bt_r] = m_rdata;
                bt_nxt = bt_r + 2'h1;
                if (!MISS_EXTRA && !we_r && bt_r == a_r[3:2]) begin
                    valid_nxt = 1'b1;
                    rdata_nxt = m_rdata;
                end
                if (bt_r == 2'h3) begin
                    tag_nxt[v_r][sr] = a_r[31 -: TW];
                    vld_nxt[v_r][sr] = 1'b1;
                    lck_nxt[v_r][sr] = (lk_r == LK_SET);
                    lru_nxt[sr] = !v_r;
                    dty_nxt[v_r][sr] = we_r;
                    if (we_r) begin
                        dat_nxt[v_r][sr][a_r[3:2]] = wd_r;
                    end
                    st_nxt = MISS_EXTRA ? CS_LATE : CS_IDLE;
                    if (!MISS_EXTRA && we_r) begin
                        valid_nxt = 1'b1;
                    end
                end
            end
            CS_LATE: begin
                valid_nxt = 1'b1;
                rdata_nxt = dat_r[v_r][sr][a_r[3:2]];
                st_nxt = CS_IDLE;
            end
            CS_SGL: if (m_ack) begin
                valid_nxt = 1'b1;
                rdata_nxt = m_rdata;
                st_nxt = CS_IDLE;
            end
            default: st_nxt = CS_IDLE;
        endcase
    end

    // Control registers; frozen while ce is low
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            vld_r <= '{default: '0};
            lck_r <= '{default: '0};
            dty_r <= '{default: '0};
            lru_r <= {SETS{`CTU_LRU_RST}};
            st_r <= CS_IDLE;
            a_r <= '0;
            wd_r <= '0;
            we_r <= 1'b0;
            lk_r <= LK_NONE;
            v_r <= 1'b0;
            bt_r <= 2'h0;
            valid_r <= 1'b0;
            rdata_r <= '0;
        end else if (ce) begin
            vld_r <= vld_nxt;
            lck_r <= lck_nxt;
            dty_r <= dty_nxt;
            lru_r <= lru_nxt;
            st_r <= st_nxt;
            a_r <= a_nxt;
            wd_r <= wd_nxt;
            we_r <= we_nxt;
            lk_r <= lk_nxt;
            v_r <= v_nxt;
            bt_r <= bt_nxt;
            valid_r <= valid_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // Tags and data need no reset: valid bits guard them
    always_ff @(posedge sys_clk) begin
        if (ce) begin
            tag_r <= tag_nxt;
            dat_r <= dat_nxt;
        end
    end

    // Memory side follows the sequencer state
    assign ready = (st_r == CS_IDLE);
    assign valid = valid_r;
    assign rdata = rdata_r;
    assign m_req = (st_r == CS_WBK) || (st_r == CS_FILL) || (st_r == CS_SGL);
    assign m_we = (st_r == CS_WBK) || (st_r == CS_SGL && we_r);
    assign m_burst = (st_r == CS_WBK) || (st_r == CS_FILL);
    assign m_addr = (st_r == CS_WBK) ? {tag_r[v_r][sr], sr, 4'h0} :
                    (st_r == CS_FILL) ? {a_r[31:4], 4'h0} : a_r;
    assign m_wdata = (st_r == CS_WBK) ? dat_r[v_r][sr][bt_r] : wd_r;

    // ************************************************
    // Checks
    // ************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst || !ce);

    sequence s_last_fill;
        st_r == CS_FILL && m_ack && bt_r == 2'h3;
    endsequence
    sequence s_alloc;
        st_r == CS_IDLE ##1 (st_r == CS_FILL || st_r == CS_WBK);
    endsequence

    property p_hit_one;
        (st_r == CS_IDLE && req && (|hit_w) && !inh && !we && lk_op == LK_NONE) |=> valid;
    endproperty
    a_hit_one: assert property (p_hit_one) else $error("hit not answered next cycle");
    property p_late;
        (s_last_fill and MISS_EXTRA) |=> st_r == CS_LATE ##1 valid;
    endproperty
    a_late: assert property (p_late) else $error("miss answer not one clock late");
    property p_crit;
        (!MISS_EXTRA && st_r == CS_FILL && m_ack && !we_r && bt_r == a_r[3:2])
            |=> valid && rdata == $past(m_rdata);
    endproperty
    a_crit: assert property (p_crit) else $error("fetched word not forwarded");
    property p_burst;
        st_r == CS_FILL |-> m_req && m_burst && !m_we && m_addr[3:0] == 4'h0;
    endproperty
    a_burst: assert property (p_burst) else $error("fill not an aligned burst");
    property p_inh;
        (st_r == CS_IDLE && req && inh && lk_op != LK_CLR) |=> st_r == CS_SGL;
    endproperty
    a_inh: assert property (p_inh) else $error("inhibited access used cache");
    property p_wt;
        (st_r == CS_IDLE && req && we && wthru && !inh && lk_op == LK_NONE)
            |=> st_r == CS_SGL && m_we;
    endproperty
    a_wt: assert property (p_wt) else $error("writethrough store not sent out");
    property p_vic;
        s_alloc |-> !lck_r[v_r][sr];
    endproperty
    a_vic: assert property (p_vic) else $error("locked line chosen as victim");
    property p_lock;
        (st_r == CS_IDLE && req && (|hit_w) && !inh && lk_op == LK_SET)
            |=> lck_r[$past(hit_w[1])][$past(si)];
    endproperty
    a_lock: assert property (p_lock) else $error("line lock not taken");
endmodule : ctu_set_cache

// ===== design/ctu_core_cache_unit.sv
// Instruction and data caches with their translation buffers and bus arbiter
`timescale 1ns/1ps
`include "ctu_cfg.svh"
module ctu_core_cache_unit import ctu_pkg::*; (
    // Clock, reset, enable
    input logic sys_clk,
    input logic rst,
    input logic ce,
    // Instruction fetch
    input logic if_req,
    input ctu_word_t if_vaddr,
    input ctu_lock_e if_lock,
    output logic if_ready,
    output logic if_valid,
    output ctu_word_t if_data,
    output logic if_fault,
    // Load and store
    input logic ls_req,
    input logic ls_we,
    input ctu_word_t ls_vaddr,
    input ctu_word_t ls_wdata,
    input ctu_lock_e ls_lock,
    output logic ls_ready,
    output logic ls_valid,
    output ctu_word_t ls_rdata,
    output logic ls_fault,
    // Current context
    input logic [3:0] cur_asid,
    input logic [15:0] grp_allow,
    // Translation entry load
    input logic tlb_we,
    input logic tlb_dside,
    input logic [2:0] tlb_idx,
    input logic [19:0] tlb_vpn,
    input logic [19:0] tlb_rpn,
    input logic [3:0] tlb_asid,
    input logic [3:0] tlb_grp,
    input ctu_pgsz_e tlb_size,
    input logic tlb_inh,
    input logic tlb_wthru,
    // Scratch registers
    input logic scr_we,
    input logic [1:0] scr_sel,
    input ctu_word_t scr_wdata,
    output ctu_word_t scr_rdata,
    // External bus
    output logic ext_req,
    output logic ext_we,
    output logic ext_burst,
    output ctu_word_t ext_addr,
    output ctu_word_t ext_wdata,
    input logic ext_ack,
    input ctu_word_t ext_rdata
);
    localparam int NE = `CTU_TLB_ENTRIES;

    // Page size to compare mask over the page number bits
    function automatic logic [19:0] pg_mask(input ctu_pgsz_e s);
        logic [19:0] m;
        m = '1;
        unique case (s)
            PG_4K: m = ~20'((20'h1 << `CTU_LOW_4K) - 20'h1);
            PG_16K: m = ~20'((20'h1 << `CTU_LOW_16K) - 20'h1);
            PG_512K: m = ~20'((20'h1 << `CTU_LOW_512K) - 20'h1);
            PG_8M: m = ~20'((20'h1 << `CTU_LOW_8M) - 20'h1);
        endcase
        return m;
    endfunction : pg_mask

    // ************************************************
    // Translation buffers, index 0 instruction, 1 data
    // ************************************************
    ctu_tlbe_s ent_r [2][NE];
    ctu_tlbe_s ent_nxt [2][NE];
    ctu_word_t va [2];
    ctu_word_t pa [2];
    logic [NE-1:0] hit_v [2];
    logic [19:0] pfn_e [2][NE];
    logic [2:0] sel [2];
    logic hit_any [2], grp_ok [2], inh [2], wt [2], rq [2], rdy [2], go [2];
    logic flt_r [2], flt_nxt [2];

    assign va[0] = if_vaddr;
    assign va[1] = ls_vaddr;
    assign rq[0] = if_req;
    assign rq[1] = ls_req;

    for (genvar t = 0; t < 2; t++) begin : g_side
        for (genvar e = 0; e < NE; e++) begin : g_ent
            logic [19:0] msk;
            assign msk = pg_mask(ent_r[t][e].sz);
            assign hit_v[t][e] = ent_r[t][e].v && ent_r[t][e].asid == cur_asid &&
                                 ((va[t][31:12] ^ ent_r[t][e].vpn) & msk) == 20'h0;
            assign pfn_e[t][e] = (ent_r[t][e].rpn & msk) | (va[t][31:12] & ~msk);
        end
    end

    // Pick the matching entry and qualify the access
    always_comb begin
        for (int t = 0; t < 2; t++) begin
            sel[t] = 3'h0;
            for (int e = 0; e < NE; e++) begin
                if (hit_v[t][e]) begin
                    sel[t] = 3'(e);
                end
            end
            hit_any[t] = |hit_v[t];
            pa[t] = {pfn_e[t][sel[t]], va[t][11:0]};
            grp_ok[t] = grp_allow[ent_r[t][sel[t]].grp];
            inh[t] = ent_r[t][sel[t]].ci;
            wt[t] = ent_r[t][sel[t]].wt;
            go[t] = rq[t] && rdy[t] && hit_any[t] && grp_ok[t];
            flt_nxt[t] = rq[t] && rdy[t] && !(hit_any[t] && grp_ok[t]);
        end
    end

    // Entry load; a write replaces the whole entry
    always_comb begin
        ent_nxt = ent_r;
        if (tlb_we) begin
            ent_nxt[tlb_dside][tlb_idx] = '{v: 1'b1, vpn: tlb_vpn, rpn: tlb_rpn,
                asid: tlb_asid, grp: tlb_grp, sz: tlb_size, ci: tlb_inh, wt: tlb_wthru};
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ent_r <= '{default: '0};
            flt_r <= '{default: 1'b0};
        end else if (ce) begin
            ent_r <= ent_nxt;
            flt_r <= flt_nxt;
        end
    end

    // ************************************************
    // Scratch registers
    // ************************************************
    ctu_word_t scr_r [`CTU_SCR_REGS];
    ctu_word_t scr_nxt [`CTU_SCR_REGS];
    ctu_word_t srd_r, srd_nxt;

    always_comb begin
        scr_nxt = scr_r;
        if (scr_we && scr_sel < 2'(`CTU_SCR_REGS)) begin
            scr_nxt[scr_sel] = scr_wdata;
        end
        srd_nxt = (scr_sel < 2'(`CTU_SCR_REGS)) ? scr_r[scr_sel] : '0;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            scr_r <= '{default: '0};
            srd_r <= '0;
        end else if (ce) begin
            scr_r <= scr_nxt;
            srd_r <= srd_nxt;
        end
    end

    assign scr_rdata = srd_r;

    // ************************************************
    // Caches and bus arbiter
    // ************************************************
    logic mreq [2], mwe [2], mbur [2], mack [2], vld [2];
    ctu_word_t madr [2], mwd [2], rdat [2];
    logic own_r, own_nxt;

    ctu_set_cache #(.SETS(`CTU_IC_SETS), .MISS_EXTRA(`CTU_IC_EXTRA)) u_icache (
        .sys_clk(sys_clk), .rst(rst), .ce(ce),
        .req(go[0]), .we(1'b0), .paddr(pa[0]), .wdata('0), .inh(inh[0]), .wthru(1'b0),
        .lk_op(if_lock), .ready(rdy[0]), .valid(vld[0]), .rdata(rdat[0]),
        .m_req(mreq[0]), .m_we(mwe[0]), .m_burst(mbur[0]), .m_addr(madr[0]),
        .m_wdata(mwd[0]), .m_ack(mack[0]), .m_rdata(ext_rdata)
    );

    ctu_set_cache #(.SETS(`CTU_DC_SETS), .MISS_EXTRA(`CTU_DC_EXTRA)) u_dcache (
        .sys_clk(sys_clk), .rst(rst), .ce(ce),
        .req(go[1]), .we(ls_we), .paddr(pa[1]), .wdata(ls_wdata), .inh(inh[1]), .wthru(wt[1]),
        .lk_op(ls_lock), .ready(rdy[1]), .valid(vld[1]), .rdata(rdat[1]),
        .m_req(mreq[1]), .m_we(mwe[1]), .m_burst(mbur[1]), .m_addr(madr[1]),
        .m_wdata(mwd[1]), .m_ack(mack[1]), .m_rdata(ext_rdata)
    );

    // Owner keeps the bus until its request drops; the current owner wins a tie
    always_comb begin
        own_nxt = (own_r ? mreq[1] : mreq[0]) ? own_r : mreq[1];
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            own_r <= 1'b0;
        end else if (ce) begin
            own_r <= own_nxt;
        end
    end

    assign ext_req = mreq[own_nxt];
    assign ext_we = mwe[own_nxt];
    assign ext_burst = mbur[own_nxt];
    assign ext_addr = madr[own_nxt];
    assign ext_wdata = mwd[own_nxt];
    assign mack[0] = ext_ack && !own_nxt;
    assign mack[1] = ext_ack && own_nxt;

    // Core side answers
    assign if_ready = rdy[0];
    assign ls_ready = rdy[1];
    assign if_valid = vld[0] || flt_r[0];
    assign ls_valid = vld[1] || flt_r[1];
    assign if_data = rdat[0];
    assign ls_rdata = rdat[1];
    assign if_fault = flt_r[0];
    assign ls_fault = flt_r[1];

    // ************************************************
    // Checks
    // ************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst || !ce);

    sequence s_scr_wr;
        scr_we && scr_sel == 2'h1 ##1 scr_sel == 2'h1 && !scr_we;
    endsequence

    property p_tlb_miss;
        (if_req && if_ready && !hit_any[0]) |=> if_fault && if_valid ##1 !if_fault;
    endproperty
    a_tlb_miss: assert property (p_tlb_miss) else $error("fetch miss in buffer not faulted");
    property p_grp;
        (ls_req && ls_ready && hit_any[1] && !grp_ok[1]) |=> ls_fault && ls_ready;
    endproperty
    a_grp: assert property (p_grp) else $error("denied group not faulted");
    property p_scr;
        s_scr_wr |=> scr_rdata == $past(scr_wdata, 2);
    endproperty
    a_scr: assert property (p_scr) else $error("scratch word not kept");
endmodule : ctu_core_cache_unit

// ===== verification/ctu_mem_model.sv
// External bus memory model for line fills, write-backs and single beats
`timescale 1ns/1ps
module ctu_mem_model import ctu_pkg::*; (
    // Clock and reset
    input logic sys_clk,
    input logic rst,
    // Bus from the unit
    input logic req,
    input logic we,
    input logic burst,
    input ctu_word_t addr,
    input ctu_word_t wdata,
    input logic slow,
    output logic ack,
    output ctu_word_t rdata
);
    ctu_word_t mem [int];
    ctu_word_t cur;
    int beat;
    int tick;
    // Beat counter and ack; slow mode stalls every other cycle
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ack <= 1'b0;
            rdata <= 32'h0;
            beat = 0;
            tick = 0;
        end else begin
            tick++;
            if (req && ack) begin
                if (we) mem[addr + 32'(beat * 4)] = wdata;
                beat = (burst && beat < 3) ? beat + 1 : 0;
            end
            cur = addr + 32'(beat * 4);
            // Unwritten words read as a pattern of their address
            rdata <= mem.exists(cur) ? mem[cur] : cur ^ 32'h5a5a0000;
            ack <= req && !(ack && beat == 0) && !(slow && tick[0]);
            // Between transfers the line carries junk, never the last word
            if (!(req && !(ack && beat == 0))) rdata <= ~cur;
        end
    end
endmodule : ctu_mem_model

// ===== verification/tb.sv
// Self-checking bench for the cache and translation unit
`timescale 1ns/1ps
module tb import ctu_pkg::*; ;
    logic sys_clk = 0, rst = 1, ce = 1, if_req = 0, ls_req = 0, ls_we = 0, slow = 0;
    logic tlb_we = 0, tlb_dside = 0, tlb_inh = 0, tlb_wthru = 0, scr_we = 0;
    ctu_word_t if_vaddr = 0, ls_vaddr = 0, ls_wdata = 0, scr_wdata = 0;
    ctu_word_t if_data, ls_rdata, scr_rdata, ext_addr, ext_wdata, ext_rdata, rd, sv [4];
    ctu_lock_e if_lock = LK_NONE, ls_lock = LK_NONE;
    ctu_pgsz_e tlb_size = PG_4K;
    logic [3:0] cur_asid = 0, tlb_asid = 0, tlb_grp = 0;
    logic [15:0] grp_allow = 16'hffdf;
    logic [2:0] tlb_idx = 0;
    logic [1:0] scr_sel = 0;
    logic [19:0] tlb_vpn = 0, tlb_rpn = 0;
    logic if_ready, if_valid, if_fault, ls_ready, ls_valid, ls_fault;
    logic ext_req, ext_we, ext_burst, ext_ack, flt;
    int fail_count = 0, checks_done = 0, beats = 0, b0, lat;
    logic [31:0] seed = 32'h18b8;
    ctu_word_t refm [int];
    ctu_core_cache_unit DUT (.sys_clk, .rst, .ce, .if_req, .if_vaddr, .if_lock, .if_ready,
        .if_valid, .if_data, .if_fault, .ls_req, .ls_we, .ls_vaddr, .ls_wdata, .ls_lock,
        .ls_ready, .ls_valid, .ls_rdata, .ls_fault, .cur_asid, .grp_allow, .tlb_we,
        .tlb_dside, .tlb_idx, .tlb_vpn, .tlb_rpn, .tlb_asid, .tlb_grp, .tlb_size, .tlb_inh,
        .tlb_wthru, .scr_we, .scr_sel, .scr_wdata, .scr_rdata, .ext_req, .ext_we, .ext_burst,
        .ext_addr, .ext_wdata, .ext_ack, .ext_rdata);
    ctu_mem_model mem (.sys_clk, .rst, .req(ext_req), .we(ext_we), .burst(ext_burst),
        .addr(ext_addr), .wdata(ext_wdata), .slow, .ack(ext_ack), .rdata(ext_rdata));
    // Clock and completed-beat count
    initial forever #2.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (ext_req && ext_ack) beats++;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic ctu_word_t expv(ctu_word_t pa);
        return refm.exists(pa) ? refm[pa] : pa ^ 32'h5a5a0000;
    endfunction : expv
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : print_verdict
    task automatic chk_w(string n, ctu_word_t e, ctu_word_t g);
        checks_done++;
        if (e !== g) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask : chk_w
    // Request on one side, wait bounded for the answer
    task automatic acc(bit d, bit w, ctu_word_t va, ctu_word_t wd);
        int n;
        repeat (2) @(posedge sys_clk);
        if (d) begin
            ls_req <= 1; ls_we <= w; ls_vaddr <= va; ls_wdata <= wd;
        end else begin
            if_req <= 1; if_vaddr <= va;
        end
        b0 = beats;
        @(posedge sys_clk);
        ls_req <= 0; if_req <= 0; lat = 1; #1;
        while (!(d ? ls_valid === 1 : if_valid === 1) && lat < 300) begin
            @(posedge sys_clk); #1; lat++;
        end
        if (lat >= 300) begin fail_count++; print_verdict(); end
        rd = d ? ls_rdata : if_data;
        flt = d ? ls_fault : if_fault;
        // A forwarded fetch word comes before the burst ends; count beats once idle again
        n = 0;
        while ((d ? ls_ready : if_ready) !== 1 && n < 300) begin
            @(posedge sys_clk); #1; n++;
        end
        if (n >= 300) begin fail_count++; print_verdict(); end
    endtask : acc
    // Read check; negative figures skip latency or beat count
    task automatic rdc(bit d, ctu_word_t va, ctu_word_t pa, int el, int eb, bit ef = 0);
        acc(d, 0, va, 0);
        chk_w("fault", 32'(ef), {31'h0, flt});
        if (!ef) chk_w("read data", expv(pa), rd);
        if (el >= 0) chk_w("latency", el, lat);
        if (eb >= 0) chk_w("bus beats", eb, beats - b0);
    endtask : rdc
    task automatic st(ctu_word_t a, ctu_word_t v, int eb);
        acc(1, 1, a, v);
        refm[a] = v;
        if (eb >= 0) chk_w("store beats", eb, beats - b0);
    endtask : st
    task automatic tlb(bit d, int i, logic [19:0] v, r, ctu_pgsz_e s, logic [3:0] a, g, bit ih, wt);
        @(posedge sys_clk);
        tlb_we <= 1; tlb_dside <= d; tlb_idx <= 3'(i); tlb_vpn <= v; tlb_rpn <= r;
        tlb_size <= s; tlb_asid <= a; tlb_grp <= g; tlb_inh <= ih; tlb_wthru <= wt;
        @(posedge sys_clk);
        tlb_we <= 0;
    endtask : tlb
    // Main sequence
    initial begin
        repeat (16) @(posedge sys_clk);
        rst <= 0;
        for (int d = 0; d < 2; d++) begin
            tlb(d, 0, 0, 0, PG_4K, 0, 0, 0, 0);
            tlb(d, 1, 20'h10, 20'h10, PG_16K, 0, 0, 1, 0);
            tlb(d, 2, 20'h80000, 20'h00800, PG_8M, 0, 0, 0, 0);
            tlb(d, 3, 3, 3, PG_4K, 0, 5, 0, 0);
            tlb(d, 4, 4, 4, PG_4K, 3, 0, 0, 0);
            tlb(d, 5, 20'h00140, 20'h00140, PG_512K, 0, 0, 0, 1);
        end
        for (int i = 0; i < 4; i++) begin
            sv[i] = rnd();
            @(posedge sys_clk) begin scr_we <= 1; scr_sel <= 2'(i); scr_wdata <= sv[i]; end
            @(posedge sys_clk) scr_we <= 0;
        end
        for (int i = 0; i < 4; i++) begin
            @(posedge sys_clk) scr_sel <= 2'(i);
            @(posedge sys_clk); #1;
            chk_w("scratch", i == 3 ? 32'h0 : sv[i], scr_rdata);
        end
        $display("test scratch done");
        rdc(0, 32'h008, 32'h008, 5, 4);
        rdc(0, 32'h000, 32'h000, 1, 0);
        rdc(0, 32'h10020, 32'h10020, -1, 1);
        rdc(0, 32'h5000, 0, -1, 0, 1);
        rdc(1, 32'h040, 32'h040, 7, 4);
        st(32'h044, rnd(), 0);
        rdc(1, 32'h044, 32'h044, 1, 0);
        rdc(1, 32'h10010, 32'h10010, -1, 1);
        rdc(1, 32'h10010, 32'h10010, -1, 1);
        rdc(1, 32'h8012_3450, 32'h0092_3450, -1, 4);
        rdc(1, 32'h140080, 32'h140080, 7, 4);
        st(32'h140084, rnd(), 1);
        for (int i = 3; i < 8; i++) rdc(1, 32'(i) << 12, 0, -1, 0, 1);
        $display("test paths done");
        rdc(1, 32'h0c0, 32'h0c0, -1, 4);
        rdc(1, 32'h2c0, 32'h2c0, -1, 4);
        rdc(1, 32'h0c0, 32'h0c0, 1, 0);
        rdc(1, 32'h4c0, 32'h4c0, -1, 4);
        rdc(1, 32'h2c0, 32'h2c0, -1, 4);
        @(posedge sys_clk) ls_lock <= LK_SET;
        rdc(1, 32'h2c0, 32'h2c0, 1, 0);
        @(posedge sys_clk) ls_lock <= LK_NONE;
        rdc(1, 32'h6c0, 32'h6c0, -1, 4);
        rdc(1, 32'h2c0, 32'h2c0, 1, 0);
        $display("test replacement done");
        slow <= 1;
        for (int i = 0; i < 30; i++) begin
            b0 = rnd() & 32'hffc;
            if (rnd() & 1) st(b0, rnd(), -1);
            else rdc(1, b0, b0, -1, -1);
        end
        $display("test random done");
        print_verdict();
    end
endmodule : tb
